//--- rtl/mpc_channel_ctrl.sv
// Purpose: Control, enable and polarity logic for two motor PWM channels
// Assumes: Register port on the internal bus; cycle and staging values come from outside
// Notes: Output pins are registered; enables are driven straight from registers
//
// Functional notes
// RL1 - Two identical independent channel register sets
// RL2 - Control bits 7 and 6 read one
// RL3 - Bit 5 gates interrupt on cycle match
// RL4 - Flag sets when counter equals cycle
// RL5 - Flag clears by zero write after reading one
// RL6 - Writing one to flag does nothing
// RL7 - Transfer controller clears flag when disable-select zero
// RL8 - Bit 3 runs or halts counter
// RL9 - Codes select divide 1, 4, 8, 16
// RL10 - Enable bits gate outputs H down to A
// RL11 - Polarity bits invert their outputs
// RL12 - Code 001 selects divide by two
// RL13 - Ten-bit counter held at H'FC00 when stopped
// RL14 - Match clears counter, loads staging into width
// RL15 - Active from clear until width match
// RL16 - Interrupt line equals flag and enable
// RL17 - Disabled pin does not drive waveform
`timescale 1ns/10ps
`default_nettype none
module mpc_channel_ctrl
    import mpc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [2:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [31:0] cycle_length,
    input wire logic [103:0] width_staging,
    input wire logic [1:0] dtc_clear_req,
    input wire logic [1:0] transfer_disable_select,
    output logic [1:0] irq,
    output logic [15:0] pwm_out,
    output logic [15:0] pwm_oe
);
    // ==========================================================
    // Read data path
    // Read data is registered and held until the next read strobe,
    // so the bus may take it any time before it reads again
    logic [7:0] rd_val [0:1][0:3]; // Per channel read values
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // Capture read value on a read strobe, hold otherwise
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            rdata_next = rd_val[reg_addr[2]][reg_addr[1:0]];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= MPC_RDATA_RST;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Data output straight from the flip-flop
    assign reg_rdata = rdata_reg;

    // ==========================================================
    // Channel logic, one copy per channel
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch // [RL1]
        logic ie_reg, ie_next; // Interrupt enable
        logic flag_reg, flag_next; // Cycle match flag
        logic armed_reg, armed_next; // Flag was read as one
        logic run_reg, run_next; // Counter run
        logic [2:0] cks_reg, cks_next; // Prescale select
        logic [7:0] oe_reg, oe_next; // Output enables
        logic [7:0] pol_reg, pol_next; // Output inversion
        logic [9:0] cnt_reg, cnt_next; // Period counter live bits
        logic [3:0] pre_reg, pre_next; // Prescale divider
        logic [51:0] duty_reg, duty_next; // Four active width words
        logic [7:0] pin_reg, pin_next; // Registered pin levels
        logic tick; // Counter clock enable
        logic match; // Cycle compare match
        logic wr_ch; // Write aimed at this channel
        logic sw_clr; // Software flag clear
        logic dtc_clr; // Transfer controller flag clear
        logic [15:0] cnt_full; // Counter as seen by comparator
        logic [15:0] cyc; // This channel's cycle value

        // Cycle value is set outside and should only change while halted
        assign cyc = cycle_length[ch*16 +: 16];
        assign cnt_full = {MPC_CNT_TOP, cnt_reg}; // [RL13]
        assign wr_ch = reg_wr && (reg_addr[2] == ch[0]);

        // Divider terminal count picks the counting edge
        // Divider free-runs while counting; the first tick after a code change
        // may come early, which only shifts the phase of one period
        always_comb begin
            case (cks_reg) // [RL9]
                MPC_CKS_DIV1: tick = 1'b1;
                MPC_CKS_DIV2: tick = (pre_reg[0] == MPC_TERM_DIV2[0]); // [RL12]
                MPC_CKS_DIV4: tick = (pre_reg[1:0] == MPC_TERM_DIV4[1:0]);
                MPC_CKS_DIV8: tick = (pre_reg[2:0] == MPC_TERM_DIV8[2:0]);
                default: tick = (pre_reg == MPC_TERM_DIV16);
            endcase
        end

        // Match only on a counting edge, so a slow prescale sees one match
        assign match = run_reg && tick && (cnt_full == cyc); // [RL4]
        // Clear only honoured after a read of one; a one written is ignored
        assign sw_clr = wr_ch && (reg_addr[1:0] == MPC_IDX_CTRL)
            && !reg_wdata[MPC_BIT_FLAG] && armed_reg; // [RL5] [RL6]
        // Controller clear is a one-cycle request after it served the match
        assign dtc_clr = dtc_clear_req[ch] && !transfer_disable_select[ch]; // [RL7]

        // Next state of registers, counter and outputs
        always_comb begin
            ie_next = ie_reg;
            run_next = run_reg;
            cks_next = cks_reg;
            oe_next = oe_reg;
            pol_next = pol_reg;
            // Set wins over a same-cycle clear, so no match is lost
            flag_next = match || (flag_reg && !(sw_clr || dtc_clr));
            // Arming remembers a read of one; it is lost whenever the flag
            // drops, so a stale read can clear a later match only if it came while the flag was still one
            armed_next = armed_reg;
            if (!flag_next) begin
                armed_next = 1'b0;
            end else if (reg_rd && (reg_addr[2] == ch[0])
                         && (reg_addr[1:0] == MPC_IDX_CTRL) && flag_reg) begin
                armed_next = 1'b1;
            end
            // Register writes; fixed top bits and index 3 keep nothing
            if (wr_ch) begin
                case (reg_addr[1:0])
                    MPC_IDX_CTRL: begin // Bits 7:6 not stored [RL2]
                        ie_next = reg_wdata[MPC_BIT_IE]; // [RL3]
                        run_next = reg_wdata[MPC_BIT_RUN]; // [RL8]
                        cks_next = reg_wdata[2:0];
                    end
                    MPC_IDX_OE: oe_next = reg_wdata;
                    MPC_IDX_POL: pol_next = reg_wdata;
                    default: ; // Unmapped index ignored
                endcase
            end
            // Counter and divider freeze at start value while halted
            pre_next = MPC_PRE_RST;
            cnt_next = MPC_CNT_CLR;
            duty_next = duty_reg;
            if (run_reg) begin // [RL8] [RL13]
                pre_next = pre_reg + MPC_PRE_ONE;
                cnt_next = cnt_reg;
                if (match) begin
                    cnt_next = MPC_CNT_CLR; // [RL14]
                    duty_next = width_staging[ch*52 +: 52]; // [RL14]
                end else if (tick) begin
                    cnt_next = cnt_reg + MPC_CNT_ONE;
                end
            end
        end

        // Waveform per output; the select bit picks which pin of a pair carries it
        // Pins lag the counter by one clock, traded for glitch-free outputs
        for (genvar k = 0; k < 8; k++) begin : g_out
            logic [12:0] w;
            logic sel;
            assign w = duty_reg[(k/2)*MPC_STG_W +: MPC_STG_W];
            assign sel = (w[MPC_BIT_OTS] == k[0]);
            // Zero width never goes active; unselected pin sits inactive
            assign pin_next[k] = (sel && run_reg && (cnt_reg < w[9:0])) // [RL15]
                ^ pol_reg[k]; // [RL11]
        end

        // Register all channel state
        // Asynchronous reset loads constants only
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                ie_reg <= 1'b0;
                flag_reg <= 1'b0;
                armed_reg <= 1'b0;
                run_reg <= 1'b0;
                cks_reg <= MPC_CKS_RST;
                oe_reg <= MPC_OE_RST;
                pol_reg <= MPC_POL_RST;
                cnt_reg <= MPC_CNT_CLR;
                pre_reg <= MPC_PRE_RST;
                duty_reg <= {4{MPC_DUTY_RST}};
                pin_reg <= 8'h00;
            end else begin
                ie_reg <= ie_next;
                flag_reg <= flag_next;
                armed_reg <= armed_next;
                run_reg <= run_next;
                cks_reg <= cks_next;
                oe_reg <= oe_next;
                pol_reg <= pol_next;
                cnt_reg <= cnt_next;
                pre_reg <= pre_next;
                duty_reg <= duty_next;
                pin_reg <= pin_next;
            end
        end

        // Read-back views of this channel
        assign rd_val[ch][MPC_IDX_CTRL] = {MPC_CTRL_FIXED, ie_reg, flag_reg,
            run_reg, cks_reg}; // [RL2]
        assign rd_val[ch][MPC_IDX_OE] = oe_reg;
        assign rd_val[ch][MPC_IDX_POL] = pol_reg;
        assign rd_val[ch][2'h3] = 8'h00;

        // Interrupt is a level; it drops with the flag or the enable
        assign irq[ch] = flag_reg && ie_reg; // [RL16] [RL3]
        // Disabled pins release to their other function
        // Output is forced low there so a released pin never shows the waveform
        assign pwm_oe[ch*8 +: 8] = oe_reg; // [RL10] [RL17]
        assign pwm_out[ch*8 +: 8] = pin_reg & oe_reg; // [RL10] [RL17]
    end
endmodule
`default_nettype wire

//--- inc/mpc_pkg.sv
// Purpose: Shared constants for the motor PWM channel control block
// Assumes: Two channels, eight outputs each, 8-bit control registers
// Notes: Register indices are selected by reg_addr[1:0]; reg_addr[2] picks the channel
package mpc_pkg;
    // ==========================================================
    // Register indices
    localparam logic [1:0] MPC_IDX_CTRL = 2'h0; // channel_control
    localparam logic [1:0] MPC_IDX_OE = 2'h1; // output_enable_control
    localparam logic [1:0] MPC_IDX_POL = 2'h2; // output_polarity_select

    // ==========================================================
    // channel_control field positions
    localparam int MPC_BIT_IE = 5; // interrupt_enable
    localparam int MPC_BIT_FLAG = 4; // cycle_match_flag
    localparam int MPC_BIT_RUN = 3; // counter_run
    localparam logic [1:0] MPC_CTRL_FIXED = 2'h3; // Bits 7:6 read as ones

    // ==========================================================
    // Reset values
    localparam logic [7:0] MPC_OE_RST = 8'h00;
    localparam logic [7:0] MPC_POL_RST = 8'h00;
    localparam logic [2:0] MPC_CKS_RST = 3'h0;
    localparam logic [7:0] MPC_RDATA_RST = 8'h00;

    // ==========================================================
    // Counter: 10 live bits, upper six read as ones (H'FC00 base)
    localparam logic [5:0] MPC_CNT_TOP = 6'h3F;
    localparam logic [9:0] MPC_CNT_CLR = 10'h000;
    localparam logic [9:0] MPC_CNT_ONE = 10'h001;
    localparam logic [3:0] MPC_PRE_RST = 4'h0;
    localparam logic [3:0] MPC_PRE_ONE = 4'h1;

    // ==========================================================
    // Prescale codes and divider terminal masks
    localparam logic [2:0] MPC_CKS_DIV1 = 3'h0;
    localparam logic [2:0] MPC_CKS_DIV2 = 3'h1;
    localparam logic [2:0] MPC_CKS_DIV4 = 3'h2;
    localparam logic [2:0] MPC_CKS_DIV8 = 3'h3;
    localparam logic [3:0] MPC_TERM_DIV2 = 4'h1;
    localparam logic [3:0] MPC_TERM_DIV4 = 4'h3;
    localparam logic [3:0] MPC_TERM_DIV8 = 4'h7;
    localparam logic [3:0] MPC_TERM_DIV16 = 4'hF;

    // ==========================================================
    // Staging word layout (13 bits per pair)
    localparam int MPC_STG_W = 13;
    localparam int MPC_BIT_OTS = 12;
    localparam logic [12:0] MPC_DUTY_RST = 13'h0000;
endpackage

//--- dv/mpc_channel_ctrl_checker.sv
// Purpose: Port assertions for mpc_channel_ctrl, channel 0
// Assumes: Match events are internal, so checks key off bus and pins
// Notes: Channel 1 shares the same logic
`timescale 1ns/10ps
`default_nettype none
module mpc_channel_ctrl_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [2:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] dtc_clear_req,
    input wire logic [1:0] transfer_disable_select,
    input wire logic [1:0] irq,
    input wire logic [15:0] pwm_out,
    input wire logic [15:0] pwm_oe
);
    // ==========================================================
    // Clocking
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic rd0 = reg_rd && reg_addr == 3'h0; // Control read, channel 0
    wire logic wr0 = reg_wr && reg_addr == 3'h0; // Control write, channel 0
    // ==========================================================
    // Assertions
    a_pin_gated: assert property ((pwm_out & ~pwm_oe) == 16'h0000)
        else $error("pin driven while disabled");
    a_fixed_bits: assert property (rd0 |=> reg_rdata[7:6] == 2'h3)
        else $error("control top bits not one");
    a_unmapped_zero: assert property (reg_rd && reg_addr[1:0] == 2'h3 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_irq_read: assert property (rd0 && !reg_wr && !dtc_clear_req[0] ##1
        reg_rdata[5] && reg_rdata[4] |-> irq[0]) else $error("irq low with flag and enable");
    a_ie_off: assert property (wr0 && !reg_wdata[5] |=> !irq[0])
        else $error("irq high with enable off");
    a_oe_load: assert property (reg_wr && reg_addr == 3'h1 |=> pwm_oe[7:0] == $past(reg_wdata))
        else $error("enable pins differ from write");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
    a_transfer_disable_select_keep: assert property (dtc_clear_req[0] && transfer_disable_select[0]
        && irq[0] && !reg_wr |=> irq[0]) else $error("flag cleared despite disable");
    c_irq: cover property ($rose(irq[0]));
    c_dtc: cover property (dtc_clear_req[0] && !transfer_disable_select[0] && irq[0]);
    c_pin: cover property ($rose(pwm_out[0]));
endmodule
`default_nettype wire

//--- dv/mpc_stage_model.sv
// Purpose: Power stage model counting active cycles on channel 0 pin A
// Assumes: Pin A is the only leg the bench watches
// Notes: A released pin drives no gate, so it never counts
`timescale 1ns/10ps
`default_nettype none
module mpc_stage_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clr,
    input wire logic [15:0] pwm_out,
    input wire logic [15:0] pwm_oe,
    output logic [15:0] on_cnt
);
    // ==========================================================
    // Gate-on counter; only an enabled pin switches the stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) on_cnt <= 16'h0000;
        else if (clr) on_cnt <= 16'h0000;
        else if (pwm_oe[0] && pwm_out[0]) on_cnt <= on_cnt + 16'h0001;
    end
endmodule
`default_nettype wire

//--- dv/mpc_channel_ctrl_bench.sv
// Purpose: Self-checking bench for mpc_channel_ctrl
// Assumes: Cycle FC03 gives four ticks a period; width word A is 1
// Notes: Inputs move 10 ns after the rising edge
`timescale 1ns/10ps
`default_nettype none
module mpc_channel_ctrl_bench import mpc_pkg::*; ;
    logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, clr = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [31:0] cycle_length = 32'h0000FC03;
    logic [103:0] width_staging = 104'h1;
    logic [1:0] dtc_clear_req = 2'h0, transfer_disable_select = 2'h0;
    wire logic [7:0] reg_rdata;
    wire logic [1:0] irq;
    wire logic [15:0] pwm_out, pwm_oe, on_cnt;
    int fails = 0, check_count = 0, cyc = 0;
    always #50 clk = ~clk;
    mpc_channel_ctrl dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cycle_length(cycle_length), .width_staging(width_staging),
        .dtc_clear_req(dtc_clear_req), .transfer_disable_select(transfer_disable_select),
        .irq(irq), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
    mpc_stage_model stage (.clk(clk), .rst_b(rst_b), .clr(clr), .pwm_out(pwm_out),
        .pwm_oe(pwm_oe), .on_cnt(on_cnt));
    // ==========================================================
    // Tasks
    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk) #10;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk) #10;
        reg_wr = 1'b0;
    endtask
    task rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk) #10;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk) #10;
        reg_rd = 1'b0;
        check({8'h00, reg_rdata}, {8'h00, e});
    endtask
    // Settle n cycles, then count pin A on-time over n cycles
    task meas(input int n, input logic [15:0] e);
        repeat (n) @(posedge clk);
        #10 clr = 1'b1;
        @(posedge clk) #10 clr = 1'b0;
        repeat (n) @(posedge clk);
        #10 check(on_cnt, e);
    endtask
    task data_transfer_controller(input logic dis);
        @(posedge clk) #10;
        transfer_disable_select = {1'b0, dis};
        dtc_clear_req = 2'h1;
        @(posedge clk) #10;
        dtc_clear_req = 2'h0;
    endtask
    task give_verdict;
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ==========================================================
    // Hang guard, well past the roughly 610 cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            give_verdict();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        #10 rst_b = 1'b1;
        rd({1'b0, MPC_IDX_CTRL}, 8'hC0);
        rd(3'h4, 8'hC0);
        rd(3'h3, 8'h00);
        wr(3'h5, 8'h3C);
        rd(3'h5, 8'h3C);
        rd(3'h1, 8'h00);
        wr(3'h0, 8'h17);
        rd(3'h0, 8'hC7);
        wr(3'h1, 8'h01);
        $display("test registers done");
        for (int k = 0; k < 5; k++) begin
            wr(3'h0, {5'h05, k[2:0]});
            meas(8 << k, 16'(2 << k));
        end
        wr(3'h2, 8'h01);
        wr(3'h0, 8'h28);
        meas(8, 16'h0006);
        wr(3'h0, 8'h30);
        meas(8, 16'h0008);
        wr(3'h1, 8'h00);
        // Channel 1 keeps the enables set in the register test, but stays halted
        check(pwm_out | pwm_oe, 16'h3C00);
        $display("test waveform done");
        rd(3'h0, 8'hF0);
        check({14'h0, irq}, 16'h0001);
        wr(3'h0, 8'h20);
        rd(3'h0, 8'hE0);
        wr(3'h0, 8'h28);
        // Let the counter reach a cycle match so the flag is set again
        repeat (4) @(posedge clk);
        wr(3'h0, 8'h20);
        rd(3'h0, 8'hF0);
        data_transfer_controller(1'b1);
        check({14'h0, irq}, 16'h0001);
        data_transfer_controller(1'b0);
        check({14'h0, irq}, 16'h0000);
        wr(3'h0, 8'h08);
        // Run long enough for one match with the interrupt disabled
        repeat (4) @(posedge clk);
        wr(3'h0, 8'h10);
        check({14'h0, irq}, 16'h0000);
        rd(3'h0, 8'hD0);
        $display("test flag done");
        give_verdict();
    end
endmodule
bind mpc_channel_ctrl mpc_channel_ctrl_checker chk (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .dtc_clear_req(dtc_clear_req),
    .transfer_disable_select(transfer_disable_select), .irq(irq), .pwm_out(pwm_out),
    .pwm_oe(pwm_oe));
`default_nettype wire
